/* include/cmd_pkg.sv */
// Constants, carriers and state layout of the cascadable multiply/divide unit
//
// Contract
// - Clear resets sequence counters, shift generator, control bits 1:0; chain pins released.
// - Clear pin or control bit 6 points sequence counters at the head unit.
// - Each strobed access steps the counter from most to least significant unit.
// - A unit answers an access other than a control write only when its count equals its position straps.
// - Four units wrap around naturally; with fewer the host resets the counter.
// - Divide: fixed holds divisor, upper:lower dividend; quotient lower, remainder upper.
// - Divisor not above upper dividend half sets overflow; both results are invalid.
// - Multiply leaves fixed times lower plus old upper in upper:lower.
// - Control bit 3 clears the upper register, bit 2 the lower register.
// - Select lines act only with chip enable and select-high; overflow gated by enable.
// - Carry out feeds the next unit; on the head an active-low overflow.
// - Right chain pins drive during multiply, left pins drive at all other times except during clear.
// - Head drives the shift pulse, others receive it; 8N+1 shifts per operation.
// - Common operate line says whether a shift pulse operates or only shifts.
// - Control bit 7 selects the prescaler; without it one shift per clock.
// - Prescaler divides by 2 for one unit, 4 for two, 8 for more.
// - Write data taken at strobe fall; strobe asynchronous; every strobe with chip enable and select-high steps counter.
// - Read codes 00..11 return fixed, lower, upper and status bytes.
// - Write codes 00..11 load fixed, lower, upper and control; strobe low does nothing.
// - Status byte carries overflow in bit 0 and zeros in bits 1 to 7.
package cmd_pkg;

    localparam int unsigned CMD_WORD_W = 8;
    localparam int unsigned CMD_STEP_W = 6;

    // Register select codes on the mid and low select lines
    localparam logic [1:0] CMD_ADDR_FIXED = 2'h0;
    localparam logic [1:0] CMD_ADDR_LOWER = 2'h1;
    localparam logic [1:0] CMD_ADDR_UPPER = 2'h2;
    localparam logic [1:0] CMD_ADDR_CTRL  = 2'h3;

    // Control word bit positions
    localparam int unsigned CMD_CTL_MUL       = 0;
    localparam int unsigned CMD_CTL_DIV       = 1;
    localparam int unsigned CMD_CTL_CLR_LOWER = 2;
    localparam int unsigned CMD_CTL_CLR_UPPER = 3;
    localparam int unsigned CMD_CTL_UNITS_LSB = 4;
    localparam int unsigned CMD_CTL_SEQ_RST   = 6;
    localparam int unsigned CMD_CTL_PRESCALE  = 7;

    // Status byte: overflow flag position
    localparam int unsigned CMD_STAT_OVF = 0;

    localparam logic [1:0] CMD_POS_HEAD = 2'h3;

    localparam logic [2:0] CMD_UNITS_BASE = 3'h4;
    localparam logic [2:0] CMD_BITS_PER_UNIT_LOG = 3'h0;
    localparam logic [CMD_STEP_W-1:0] CMD_EXTRA_SHIFT = 6'h01;

    // Prescaler reload values: clock cycles per shift minus one
    localparam logic [2:0] CMD_PRE_ONE_UNIT  = 3'h1;
    localparam logic [2:0] CMD_PRE_TWO_UNITS = 3'h3;
    localparam logic [2:0] CMD_PRE_MANY      = 3'h7;

    typedef enum logic [0:0] {CMD_IDLE, CMD_RUN} cmd_phase_t;

    typedef struct packed {
        logic y_left;
        logic y_right;
        logic z_left;
        logic z_right;
    } cmd_chain_t;

    typedef struct packed {
        logic                  clear_n;
        logic                  chip_enable;
        logic                  sel_hi;
        logic                  sel_mid;
        logic                  sel_lo;
        logic                  read_enable;
        logic                  strobe;
        logic [CMD_WORD_W-1:0] data;
        logic [1:0]            pos;
    } cmd_pins_t;

    typedef struct packed {
        logic [CMD_WORD_W-1:0] fixed;
        logic [CMD_WORD_W-1:0] upper;
        logic [CMD_WORD_W-1:0] lower;
        logic [CMD_WORD_W-1:0] ctrl;
        logic                  ovf;
        logic                  spill;
        logic [1:0]            seq;
        cmd_phase_t            phase;
        logic [CMD_STEP_W-1:0] step;
        logic [CMD_STEP_W-1:0] shifts_left;
        logic [2:0]            pre_cnt;
        logic                  shift;
        logic                  shift_oe;
        logic                  stb_prev;
        logic [CMD_WORD_W-1:0] bus_out;
        logic                  bus_oe;
        cmd_chain_t            chain_oe;
    } cmd_state_t;

    localparam cmd_state_t CMD_STATE_RESET = '0;

    // Units in the chain from the control code in bits 5:4
    function automatic logic [2:0] cmd_unit_count(input logic [1:0] code);
        return 3'(CMD_UNITS_BASE - {1'b0, code});
    endfunction : cmd_unit_count

    // Shift pulses per operation, 8N+1
    function automatic logic [CMD_STEP_W-1:0] cmd_total_shifts(input logic [1:0] code);
        return {cmd_unit_count(code), CMD_BITS_PER_UNIT_LOG} + CMD_EXTRA_SHIFT;
    endfunction : cmd_total_shifts

    function automatic logic [2:0] cmd_prescale_max(input logic [1:0] code);
        logic [2:0] units;
        units = cmd_unit_count(code);
        if (units == 3'h1) begin
            return CMD_PRE_ONE_UNIT;
        end else if (units == 3'h2) begin
            return CMD_PRE_TWO_UNITS;
        end
        return CMD_PRE_MANY;
    endfunction : cmd_prescale_max

endpackage : cmd_pkg

/* logic/cmd_pin_sync.sv */
`timescale 1ns/1ps
// Three-stage pin synchroniser with agreement filter
module cmd_pin_sync #(
    parameter int unsigned WIDTH = 1
) (
    // Clock and reset
    input  wire logic             i_clock,
    input  wire logic             i_rst,
    // Raw pins and filtered levels
    input  wire logic [WIDTH-1:0] i_pin,
    output logic      [WIDTH-1:0] o_level
);

    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
        logic [WIDTH-1:0] s3;
        logic [WIDTH-1:0] level;
    } cmd_sync_state_t;

    cmd_sync_state_t sync_q;
    cmd_sync_state_t sync_d;

    if (WIDTH < 1) begin : g_bad_width
        $error("cmd_pin_sync needs at least one bit");
    end

    // Stage one feeds stage two only; a change counts when stages two and three agree
    always_comb begin
        sync_d       = sync_q;
        sync_d.s1    = i_pin;
        sync_d.s2    = sync_q.s1;
        sync_d.s3    = sync_q.s2;
        sync_d.level = (sync_q.s2 & sync_q.s3) | (sync_q.level & (sync_q.s2 | sync_q.s3));
    end

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            sync_q <= '0;
        end else begin
            sync_q <= sync_d;
        end
    end

    assign o_level = sync_q.level;

endmodule : cmd_pin_sync

/* logic/cmd_unit.sv */
`timescale 1ns/1ps
// One cascadable multiply/divide slice: host bus, sequencing, shift engine, chain pins
module cmd_unit
    import cmd_pkg::*;
(
    // Clock and reset
    input  wire logic                  i_clock,
    input  wire logic                  i_rst,
    // Host bus pins
    input  wire logic                  i_clear_n,
    input  wire logic                  i_chip_enable,
    input  wire logic                  i_reg_select_hi,
    input  wire logic                  i_reg_select_mid,
    input  wire logic                  i_reg_select_lo,
    input  wire logic                  i_read_enable,
    input  wire logic                  i_bus_strobe,
    input  wire logic [CMD_WORD_W-1:0] i_bus_data,
    output logic      [CMD_WORD_W-1:0] o_bus_data,
    output logic                       o_bus_oe,
    // Position straps
    input  wire logic                  i_position_code_hi,
    input  wire logic                  i_position_code_lo,
    // Cascade carry, operate line and shift timing
    input  wire logic                  i_carry_input_n,
    output logic                       o_carry_out_n,
    output logic                       o_carry_out_oe,
    input  wire logic                  i_operate_or_shift_line,
    input  wire logic                  i_shift,
    output logic                       o_shift,
    output logic                       o_shift_oe,
    // Serial chain pins
    input  wire cmd_chain_t            i_chain,
    output cmd_chain_t                 o_chain,
    output cmd_chain_t                 o_chain_oe
);

    localparam int unsigned PIN_W = $bits(cmd_pins_t);

    cmd_state_t st_q;
    cmd_state_t st_d;

    cmd_pins_t        pin_raw;
    cmd_pins_t        pin;
    logic [PIN_W-1:0] pin_level;

    logic                  is_head;
    logic                  enabled;
    logic                  selected;
    logic                  stb_fall;
    logic                  clearing;
    logic                  pulse;
    logic                  mul_run;
    logic                  div_run;
    logic                  last_step;
    logic                  operate;
    logic                  cin;
    logic                  carry_comb;
    logic                  decide;
    logic                  mul_next;
    logic [1:0]            addr;
    logic [1:0]            unit_code;
    logic [CMD_STEP_W-1:0] total;
    logic [CMD_WORD_W:0]   sum;
    logic [CMD_WORD_W:0]   diff;
    logic [CMD_WORD_W-1:0] upper_op;

    // Host bus and straps come from outside the clock domain
    assign pin_raw = '{
        clear_n:     i_clear_n,
        chip_enable: i_chip_enable,
        sel_hi:      i_reg_select_hi,
        sel_mid:     i_reg_select_mid,
        sel_lo:      i_reg_select_lo,
        read_enable: i_read_enable,
        strobe:      i_bus_strobe,
        data:        i_bus_data,
        pos:         {i_position_code_hi, i_position_code_lo}
    };

    cmd_pin_sync #(
        .WIDTH (PIN_W)
    ) u_pin_sync (
        .i_clock (i_clock),
        .i_rst   (i_rst),
        .i_pin   (pin_raw),
        .o_level (pin_level)
    );

    assign pin = cmd_pins_t'(pin_level);

    assign is_head   = (pin.pos == CMD_POS_HEAD);
    // select lines need enable and select-high
    assign enabled   = pin.chip_enable & pin.sel_hi;
    assign addr      = {pin.sel_mid, pin.sel_lo};
    assign selected  = (st_q.seq == pin.pos);
    assign stb_fall  = st_q.stb_prev & ~pin.strobe;
    assign clearing  = ~pin.clear_n;

    // unit count code in bits 5:4
    assign unit_code = st_q.ctrl[CMD_CTL_UNITS_LSB +: 2];
    assign total     = cmd_total_shifts(unit_code);
    assign last_step = (st_q.step == total - CMD_EXTRA_SHIFT);

    // head uses its own pulse, the others the shared pin
    assign pulse     = is_head ? st_q.shift : i_shift;
    assign mul_run   = (st_q.phase == CMD_RUN) & st_q.ctrl[CMD_CTL_MUL];
    assign div_run   = (st_q.phase == CMD_RUN) & ~st_q.ctrl[CMD_CTL_MUL]
                       & st_q.ctrl[CMD_CTL_DIV];

    // operate line gates the add or subtract; first pulse never operates
    assign operate   = i_operate_or_shift_line & (st_q.step != '0);

    // Carry ripples through the chain inside one clock; active-low pin
    assign cin       = ~i_carry_input_n;
    assign sum       = {1'b0, st_q.upper} + {1'b0, st_q.fixed}
                       + {{CMD_WORD_W{1'b0}}, cin};
    assign diff      = {1'b0, st_q.upper} - {1'b0, st_q.fixed}
                       - {{CMD_WORD_W{1'b0}}, cin};
    assign carry_comb = mul_run ? sum[CMD_WORD_W] : diff[CMD_WORD_W];

    // Head decides a divide step: spilled bit or no borrow means upper >= divisor
    assign decide    = st_q.spill | ~diff[CMD_WORD_W];

    always_comb begin
        upper_op = st_q.upper;
        if (operate && mul_run) begin
            upper_op = sum[CMD_WORD_W-1:0];
        end else if (operate && div_run) begin
            upper_op = diff[CMD_WORD_W-1:0];
        end
    end

    always_comb begin
        st_d          = st_q;
        st_d.stb_prev = pin.strobe;
        st_d.shift    = 1'b0;

        // read path, registered onto the bus
        st_d.bus_oe = enabled & pin.read_enable & selected & pin.clear_n;
        unique case (addr)
            CMD_ADDR_FIXED: st_d.bus_out = st_q.fixed;
            CMD_ADDR_LOWER: st_d.bus_out = st_q.lower;
            CMD_ADDR_UPPER: st_d.bus_out = st_q.upper;
            // overflow in bit 0, the rest zero
            CMD_ADDR_CTRL: begin
                st_d.bus_out               = '0;
                st_d.bus_out[CMD_STAT_OVF] = st_q.ovf;
            end
        endcase

        // shift generator on the head only
        if (is_head && st_q.shifts_left != '0) begin
            if (st_q.pre_cnt == '0) begin
                st_d.shift       = 1'b1;
                st_d.shifts_left = st_q.shifts_left - CMD_EXTRA_SHIFT;
                if (st_q.ctrl[CMD_CTL_PRESCALE]) begin
                    // divide by 2, 4 or 8
                    st_d.pre_cnt = cmd_prescale_max(unit_code);
                end else begin
                    st_d.pre_cnt = '0;
                end
            end else begin
                st_d.pre_cnt = st_q.pre_cnt - 3'h1;
            end
        end

        if (pulse && st_q.phase == CMD_RUN) begin
            if (mul_run) begin
                if (st_q.step != '0) begin
                    st_d.upper = {is_head ? (operate & sum[CMD_WORD_W]) : i_chain.y_left,
                                  upper_op[CMD_WORD_W-1:1]};
                    st_d.lower = {i_chain.z_left, st_q.lower[CMD_WORD_W-1:1]};
                end
            end else if (div_run) begin
                // overflow is the decision seen at the first pulse
                if (st_q.step == '0) begin
                    st_d.ovf = i_operate_or_shift_line;
                end
                // subtract and shift left; quotient bits enter lower
                if (!last_step) begin
                    st_d.upper = {upper_op[CMD_WORD_W-2:0], i_chain.y_right};
                    st_d.spill = upper_op[CMD_WORD_W-1];
                end else begin
                    st_d.upper = upper_op;
                end
                st_d.lower = {st_q.lower[CMD_WORD_W-2:0], i_chain.z_right};
            end
            if (last_step) begin
                st_d.phase = CMD_IDLE;
            end else begin
                st_d.step = st_q.step + CMD_EXTRA_SHIFT;
            end
        end

        if (enabled && stb_fall) begin
            // every strobed access steps the counter
            // four units wrap by modulo count
            st_d.seq = st_q.seq - 2'h1;
            if (!pin.read_enable) begin
                if (addr == CMD_ADDR_CTRL) begin
                    // Control word reaches every unit at once
                    st_d.ctrl  = pin.data;
                    st_d.ovf   = 1'b0;
                    st_d.spill = 1'b0;
                    if (pin.data[CMD_CTL_CLR_UPPER]) begin
                        st_d.upper = '0;
                    end
                    if (pin.data[CMD_CTL_CLR_LOWER]) begin
                        st_d.lower = '0;
                    end
                    if (pin.data[CMD_CTL_SEQ_RST]) begin
                        st_d.seq = CMD_POS_HEAD;
                    end
                    // bits 1:0 start multiply or divide
                    if (pin.data[CMD_CTL_MUL] || pin.data[CMD_CTL_DIV]) begin
                        st_d.phase       = CMD_RUN;
                        st_d.step        = '0;
                        st_d.pre_cnt     = '0;
                        st_d.shifts_left = is_head
                            ? cmd_total_shifts(pin.data[CMD_CTL_UNITS_LSB +: 2]) : '0;
                    end else begin
                        st_d.phase       = CMD_IDLE;
                        st_d.shifts_left = '0;
                    end
                end else if (selected) begin
                    if (addr == CMD_ADDR_FIXED) begin
                        st_d.fixed = pin.data;
                    end else if (addr == CMD_ADDR_LOWER) begin
                        st_d.lower = pin.data;
                    end else begin
                        st_d.upper = pin.data;
                    end
                end
            end
        end

        if (clearing) begin
            st_d.seq         = CMD_POS_HEAD;
            st_d.shifts_left = '0;
            st_d.pre_cnt     = '0;
            st_d.shift       = 1'b0;
            st_d.phase       = CMD_IDLE;
            st_d.ctrl[CMD_CTL_DIV:CMD_CTL_MUL] = 2'h0;
            st_d.bus_oe      = 1'b0;
        end

        // direction follows the mode of the next cycle
        mul_next = (st_d.phase == CMD_RUN) & st_d.ctrl[CMD_CTL_MUL];
        if (clearing) begin
            st_d.chain_oe = '0;
        end else if (mul_next) begin
            st_d.chain_oe = '{y_left: 1'b0, y_right: 1'b1, z_left: 1'b0, z_right: 1'b1};
        end else begin
            st_d.chain_oe = '{y_left: 1'b1, y_right: 1'b0, z_left: 1'b1, z_right: 1'b0};
        end

        // shift pin drives only on the head
        st_d.shift_oe = is_head & ~clearing;
    end

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            st_q <= CMD_STATE_RESET;
        end else begin
            st_q <= st_d;
        end
    end

    // Chain data; post-operate bits must ripple within the same shift
    assign o_chain = '{
        y_left:  (is_head && div_run) ? decide : upper_op[CMD_WORD_W-1],
        y_right: upper_op[0],
        z_left:  st_q.lower[CMD_WORD_W-1],
        z_right: st_q.lower[0]
    };
    assign o_chain_oe = st_q.chain_oe;

    // head shows active-low overflow, others pass carry on
    assign o_carry_out_n  = is_head ? ~st_q.ovf : ~carry_comb;
    // only chip enable gates the head's overflow pin
    assign o_carry_out_oe = is_head ? pin.chip_enable : 1'b1;

    assign o_shift    = st_q.shift;
    assign o_shift_oe = st_q.shift_oe;
    assign o_bus_data = st_q.bus_out;
    assign o_bus_oe   = st_q.bus_oe;

endmodule : cmd_unit

/* test/cmd_unit_checker.sv */
// Port-level assertions for the multiply/divide slice
`timescale 1ns/1ps
module cmd_unit_checker
    import cmd_pkg::*;
(
    // Clock and reset
    input wire logic       i_clock,
    input wire logic       i_rst,
    // Watched pins
    input wire logic       i_clear_n,
    input wire logic       i_chip_enable,
    input wire logic       i_reg_select_hi,
    input wire logic       i_read_enable,
    input wire logic       i_position_code_hi,
    input wire logic       i_position_code_lo,
    input wire logic       o_bus_oe,
    input wire logic       o_carry_out_oe,
    input wire logic       o_shift,
    input wire logic       o_shift_oe,
    input wire cmd_chain_t o_chain_oe
);
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_rst);

    // Pins pass a synchroniser, so a level counts only after several cycles
    sequence s_ce_low;
        !i_chip_enable [*7];
    endsequence
    sequence s_ce_high;
        i_chip_enable [*7];
    endsequence
    sequence s_clearing;
        !i_clear_n [*7];
    endsequence

    ce_float_a: assert property (s_ce_low |-> !o_bus_oe)
        else $error("bus driven while disabled");
    sel_float_a: assert property (!i_reg_select_hi [*7] |-> !o_bus_oe)
        else $error("bus driven without select high");
    write_float_a: assert property (!i_read_enable [*7] |-> !o_bus_oe)
        else $error("bus driven during write");
    ovf_gate_on_a: assert property (s_ce_high |-> o_carry_out_oe)
        else $error("overflow pin not driven while enabled");
    ovf_gate_off_a: assert property ((s_ce_low and i_position_code_hi && i_position_code_lo [*7])
        |-> !o_carry_out_oe) else $error("head overflow pin driven while disabled");
    clear_quiet_a: assert property (s_clearing |-> (o_chain_oe == '0) && !o_shift_oe && !o_bus_oe)
        else $error("pins driven during clear");
    shift_drive_a: assert property (o_shift |-> o_shift_oe)
        else $error("shift pulse without drive");
    mul_dir_a: assert property (o_chain_oe.y_right |-> o_chain_oe.z_right && !o_chain_oe.y_left
        && !o_chain_oe.z_left) else $error("right pins not paired");
    idle_dir_a: assert property (o_chain_oe.y_left |-> o_chain_oe.z_left && !o_chain_oe.z_right)
        else $error("left pins not paired");
endmodule : cmd_unit_checker

bind cmd_unit cmd_unit_checker u_chk (.*);

/* test/cmd_host_bfm.sv */
// Host byte-bus model: strobed register cycles and clear pulses
`timescale 1ns/1ps
module cmd_host_bfm
    import cmd_pkg::*;
(
    // Clock
    input  wire logic                  i_clock,
    // Read-back from the unit
    input  wire logic [CMD_WORD_W-1:0] i_bus_data,
    input  wire logic                  i_bus_oe,
    // Bus pins toward the unit
    output logic                       o_clear_n,
    output logic                       o_chip_enable,
    output logic                       o_reg_select_hi,
    output logic [1:0]                 o_code,
    output logic                       o_read_enable,
    output logic                       o_bus_strobe,
    output logic [CMD_WORD_W-1:0]      o_bus_data
);
    logic [CMD_WORD_W-1:0] seen;
    logic                  seen_oe;

    initial begin
        o_clear_n       = 1'b0;
        o_chip_enable   = 1'b0;
        o_reg_select_hi = 1'b0;
        o_code          = 2'h0;
        o_read_enable   = 1'b0;
        o_bus_strobe    = 1'b0;
        o_bus_data      = 8'h5a;
    end

    // One strobed access; en is {chip enable, select high}
    task automatic cyc(input logic [1:0] en, input logic rd, input logic [1:0] a,
                       input logic [CMD_WORD_W-1:0] d);
        @(posedge i_clock);
        {o_chip_enable, o_reg_select_hi} <= en;
        o_read_enable <= rd;
        o_code        <= a;
        o_bus_data    <= d;
        o_bus_strobe  <= 1'b1;
        // Longer than the pin synchroniser on both phases
        repeat (8) @(posedge i_clock);
        seen    = i_bus_oe ? i_bus_data : ~i_bus_data;
        seen_oe = i_bus_oe;
        o_bus_strobe <= 1'b0;
        repeat (6) @(posedge i_clock);
        {o_chip_enable, o_reg_select_hi} <= 2'b00;
        o_read_enable <= 1'b0;
        // Released bus changes, so a stale byte cannot pass
        o_bus_data    <= ~d;
    endtask : cyc

    // write cycle with chip enable and select high both driven
    task automatic wr(input logic [1:0] a, input logic [CMD_WORD_W-1:0] d);
        cyc(2'b11, 1'b0, a, d);
    endtask : wr

    task automatic clr();
        @(posedge i_clock);
        o_clear_n <= 1'b0;
        repeat (8) @(posedge i_clock);
        o_clear_n <= 1'b1;
        repeat (8) @(posedge i_clock);
    endtask : clr
endmodule : cmd_host_bfm

/* test/tb.sv */
// Self-checking bench for one head slice with its chain pins looped back
`timescale 1ns/1ps
module tb
    import cmd_pkg::*;
;

    logic                  i_clock = 1'b0;
    logic                  i_rst   = 1'b1;
    logic                  idle_t  = 1'b0;
    logic                  clear_n, ce, sel_hi, rd_en, stb, bus_oe, carry_n, carry_oe;
    logic                  shift, shift_oe, ctl_w, loop_w;
    logic [1:0]            code;
    logic [CMD_WORD_W-1:0] din, dout;
    cmd_chain_t            chain_o, chain_oe;
    int                    n_mismatch = 0;
    int                    checked = 0;
    int                    shift_n = 0;
    int                    shift_first = 0;
    int                    shift_last = 0;
    int                    cycle_n = 0;

    always #20 i_clock = ~i_clock;

    // One slice: operate line, Y-left and Z-right share a wire; Y-right meets Z-left
    assign ctl_w  = chain_oe.y_left ? chain_o.y_left : chain_oe.z_right ? chain_o.z_right : idle_t;
    assign loop_w = chain_oe.y_right ? chain_o.y_right : chain_oe.z_left ? chain_o.z_left : ~idle_t;

    always @(posedge i_clock) begin
        idle_t  <= ~idle_t;
        cycle_n <= cycle_n + 1;
        if (shift === 1'b1) begin
            shift_n    <= shift_n + 1;
            shift_last <= cycle_n;
            if (cycle_n - shift_last > 4) shift_first <= cycle_n;
        end
    end

    cmd_host_bfm host (.i_clock(i_clock), .i_bus_data(dout), .i_bus_oe(bus_oe),
        .o_clear_n(clear_n), .o_chip_enable(ce), .o_reg_select_hi(sel_hi), .o_code(code),
        .o_read_enable(rd_en), .o_bus_strobe(stb), .o_bus_data(din));

    cmd_unit uut (.i_clock(i_clock), .i_rst(i_rst), .i_clear_n(clear_n), .i_chip_enable(ce),
        .i_reg_select_hi(sel_hi), .i_reg_select_mid(code[1]), .i_reg_select_lo(code[0]),
        .i_read_enable(rd_en), .i_bus_strobe(stb), .i_bus_data(din), .o_bus_data(dout),
        .o_bus_oe(bus_oe), .i_position_code_hi(1'b1), .i_position_code_lo(1'b1),
        .i_carry_input_n(1'b1), .o_carry_out_n(carry_n), .o_carry_out_oe(carry_oe),
        .i_operate_or_shift_line(ctl_w), .i_shift(1'b0), .o_shift(shift), .o_shift_oe(shift_oe),
        .i_chain({ctl_w, loop_w, loop_w, ctl_w}), .o_chain(chain_o), .o_chain_oe(chain_oe));

    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    // Single slice matches only at count 3, so each access starts a fresh sequence
    task automatic put(input logic [1:0] a, input logic [7:0] d);
        host.wr(CMD_ADDR_CTRL, 8'h70);
        host.wr(a, d);
    endtask : put

    task automatic get(input string nm, input logic [1:0] a, input logic [7:0] exp);
        host.wr(CMD_ADDR_CTRL, 8'h70);
        host.cyc(2'b11, 1'b1, a, 8'h00);
        chk({nm, " oe"}, 8'(host.seen_oe), 8'h01);
        chk(nm, host.seen, exp);
    endtask : get

    task automatic t_mul(input logic [7:0] ctl, input logic [7:0] span);
        int n0;
        put(CMD_ADDR_FIXED, 8'hc8);
        put(CMD_ADDR_LOWER, 8'h9b);
        put(CMD_ADDR_UPPER, 8'h37);
        n0 = shift_n;
        host.wr(CMD_ADDR_CTRL, ctl);
        repeat (40) @(posedge i_clock);
        chk("shifts", 8'(shift_n - n0), 8'h09);
        chk("span", 8'(shift_last - shift_first), span);
        get("upper", CMD_ADDR_UPPER, 8'h79);
        get("lower", CMD_ADDR_LOWER, 8'h4f);
        get("fixed", CMD_ADDR_FIXED, 8'hc8);
    endtask : t_mul

    task automatic t_div(input logic [7:0] x, y, z, q, r, input logic ovf);
        put(CMD_ADDR_FIXED, x);
        put(CMD_ADDR_UPPER, y);
        put(CMD_ADDR_LOWER, z);
        // never start a divide by zero
        if (x != 8'h00) host.wr(CMD_ADDR_CTRL, 8'h72);
        repeat (40) @(posedge i_clock);
        chk("carry", 8'(carry_n), 8'(!ovf));
        chk("carry oe", 8'(carry_oe), 8'h00);
        host.cyc(2'b11, 1'b1, CMD_ADDR_CTRL, 8'h00);
        chk("status", host.seen, 8'(ovf));
        if (!ovf) begin
            get("quotient", CMD_ADDR_LOWER, q);
            get("remainder", CMD_ADDR_UPPER, r);
            get("divisor", CMD_ADDR_FIXED, x);
        end
    endtask : t_div

    task automatic t_clrbits();
        host.wr(CMD_ADDR_CTRL, 8'h7c);
        chk("carry rearm", 8'(carry_n), 8'h01);
        get("upper", CMD_ADDR_UPPER, 8'h00);
        get("lower", CMD_ADDR_LOWER, 8'h00);
    endtask : t_clrbits

    task automatic t_seq();
        host.wr(CMD_ADDR_CTRL, 8'h70);
        for (int i = 0; i < 5; i++) begin
            host.cyc(2'b11, 1'b1, CMD_ADDR_LOWER, 8'h00);
            chk("seq oe", 8'(host.seen_oe), 8'((i == 0) || (i == 4)));
        end
    endtask : t_seq

    task automatic t_gate();
        host.wr(CMD_ADDR_CTRL, 8'h70);
        host.cyc(2'b01, 1'b0, CMD_ADDR_FIXED, 8'h99);
        host.cyc(2'b10, 1'b1, CMD_ADDR_FIXED, 8'h00);
        chk("gated oe", 8'(host.seen_oe), 8'h00);
        host.cyc(2'b11, 1'b1, CMD_ADDR_FIXED, 8'h00);
        chk("kept fixed", host.seen, 8'h05);
    endtask : t_gate

    task automatic t_clear();
        int n0;
        n0 = shift_n;
        host.wr(CMD_ADDR_CTRL, 8'hf1);
        host.clr();
        chk("aborted", 8'(shift_n - n0 < 9), 8'h01);
        host.cyc(2'b11, 1'b1, CMD_ADDR_FIXED, 8'h00);
        host.clr();
        host.cyc(2'b11, 1'b1, CMD_ADDR_FIXED, 8'h00);
        chk("head after clear", 8'(host.seen_oe), 8'h01);
        chk("shift oe", 8'(shift_oe), 8'h01);
    endtask : t_clear

    task automatic final_report();
        if (n_mismatch == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : final_report

    initial begin
        repeat (5) @(posedge i_clock);
        i_rst <= 1'b0;
        host.clr();
        get("status", CMD_ADDR_CTRL, 8'h00);
        t_mul(8'h71, 8'h08);
        t_mul(8'hf1, 8'h10);
        t_div(8'h0d, 8'h05, 8'h23, 8'h65, 8'h02, 1'b0);
        t_div(8'h05, 8'h05, 8'h00, 8'h00, 8'h00, 1'b1);
        t_clrbits();
        t_seq();
        t_gate();
        t_clear();
        final_report();
    end

    initial begin
        repeat (20000) @(posedge i_clock);
        n_mismatch++;
        final_report();
    end
endmodule : tb
